// [hbs_pkg.sv]
// Package of the holding-brake sequencer: register map, reset values, limits and timing constants.
// Assumes a 100 MHz system clock and a plain byte-addressed register port, one 32-bit register every four bytes.
package hbs_pkg;

  // Clock and timebase.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;

  // Register port widths.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PARAM_W = 16;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] ADDR_CMD_DELAY = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_HOLD_TIME = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SPEED_THR = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_WAIT_TMO = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;

  // Reset values, in ms or rpm.
  localparam logic [PARAM_W-1:0] RST_CMD_DELAY = 16'h00fa;
  localparam logic [PARAM_W-1:0] RST_HOLD_TIME = 16'h0096;
  localparam logic [PARAM_W-1:0] RST_SPEED_THR = 16'h001e;
  localparam logic [PARAM_W-1:0] RST_WAIT_TMO = 16'h01f4;

  // Legal ranges; writes outside are saturated.
  localparam logic [PARAM_W-1:0] MAX_CMD_DELAY = 16'h01f4;
  localparam logic [PARAM_W-1:0] MIN_HOLD_TIME = 16'h0001;
  localparam logic [PARAM_W-1:0] MAX_HOLD_TIME = 16'h03e8;
  localparam logic [PARAM_W-1:0] MAX_SPEED_THR = 16'h0bb8;
  localparam logic [PARAM_W-1:0] MIN_WAIT_TMO = 16'h0001;
  localparam logic [PARAM_W-1:0] MAX_WAIT_TMO = 16'h03e8;

  // Fixed limits of the stop sequences.
  localparam logic [PARAM_W-1:0] STATIC_LIMIT_RPM = 16'h001e;
  localparam logic [PARAM_W-1:0] MOVE_HOLD_MS = 16'h0032;

  // Control register fields and their reset values.
  localparam int unsigned CTRL_SWITCH_BIT = 0;
  localparam int unsigned CTRL_ASSIGN_BIT = 1;
  localparam logic RST_SWITCH = 1'b1;
  localparam logic RST_ASSIGN = 1'b0;

  // Status register field positions.
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_BRAKE_BIT = 4;
  localparam int unsigned STAT_POWER_BIT = 5;
  localparam int unsigned STAT_STOP_BIT = 6;
  localparam int unsigned STAT_READY_BIT = 7;
  localparam int unsigned STAT_ENABLE_BIT = 8;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_DISABLED = 3'b000,
    ST_ENABLED = 3'b001,
    ST_STATIC_HOLD = 3'b010,
    ST_MOVE_WAIT = 3'b011,
    ST_MOVE_HOLD = 3'b100
  } hbs_state_t;

endpackage

// [hbs_tick_if.sv]
// Interface between the sequencer and its millisecond tick generator.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface hbs_tick_if;
  logic restart;
  logic tick;

  // The generator restarts on request and pulses the tick once per period.
  modport gen (input restart, output tick);
  modport user (output restart, input tick);
endinterface
`default_nettype wire

// [hbs_tick_gen.sv]
// Millisecond tick generator for the sequencer timers.
// Assumes the system clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module hbs_tick_gen #(
  parameter int unsigned TICK_CYCLES = hbs_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Tick port.
  hbs_tick_if.gen tick_if
);
  localparam int unsigned CNT_W = $clog2(TICK_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

  logic [CNT_W-1:0] cnt_q;
  logic tick_q;
  logic wrap;

  // A restart realigns the period so a timer started now sees its first tick a full period later.
  assign wrap = (cnt_q == LAST);
  assign tick_if.tick = tick_q;

  // Period counter and tick pulse.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || tick_if.restart) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + CNT_W'(1);
      tick_q <= wrap;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_tick_single: assert property (tick_q |=> !tick_q)
    else $error("Tick lasted more than one cycle.");
  a_tick_restart: assert property (tick_if.restart |=> !tick_q && cnt_q == '0)
    else $error("Restart did not realign the tick period.");
endmodule
`default_nettype wire

// [hbs_brake_seq.sv]
// Holding-brake sequencer top: brake release output and power stage around servo enable.
// Assumes a 100 MHz clock, speed in rpm from same-clock logic, and servo enable from a pin.
`timescale 1ns/1ps
`default_nettype none
module hbs_brake_seq #(
  parameter int unsigned TICK_CYCLES = hbs_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register port.
  input wire logic [hbs_pkg::ADDR_W-1:0] addr_i,
  input wire logic [hbs_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [hbs_pkg::DATA_W-1:0] rdata_o,
  // Drive state.
  input wire logic servo_enable_i,
  input wire logic [hbs_pkg::PARAM_W-1:0] motor_speed_i,
  // Brake and power stage.
  output logic brake_release_o,
  output logic power_stage_o,
  output logic zero_speed_stop_o,
  output logic cmd_ready_o
);
  localparam int unsigned PW = hbs_pkg::PARAM_W;

  hbs_tick_if tick_if ();

  hbs_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_if(tick_if)
  );

  // Registers.
  logic [PW-1:0] cmd_delay_q;
  logic [PW-1:0] hold_time_q;
  logic [PW-1:0] speed_thr_q;
  logic [PW-1:0] wait_tmo_q;
  logic switch_q;
  logic assign_q;
  logic [hbs_pkg::DATA_W-1:0] rdata_q;
  // Enable synchroniser and filtered level.
  logic en_s1_q;
  logic en_s2_q;
  logic en_s3_q;
  logic en_level_q;
  // Sequencer.
  hbs_pkg::hbs_state_t state_q;
  hbs_pkg::hbs_state_t state_d;
  logic [PW-1:0] ms_cnt_q;
  logic [PW-1:0] ms_cnt_d;
  logic brake_q;
  logic power_q;
  logic stop_q;
  logic ready_q;

  // Write decode.
  logic wr_cmd;
  logic wr_hold;
  logic wr_thr;
  logic wr_tmo;
  logic wr_ctrl;
  logic [PW-1:0] wval;
  logic [PW-1:0] cmd_wval;
  logic [PW-1:0] hold_wval;
  logic [PW-1:0] thr_wval;
  logic [PW-1:0] tmo_wval;

  assign wval = wdata_i[PW-1:0];
  assign wr_cmd = wr_i && (addr_i == hbs_pkg::ADDR_CMD_DELAY);
  assign wr_hold = wr_i && (addr_i == hbs_pkg::ADDR_HOLD_TIME);
  assign wr_thr = wr_i && (addr_i == hbs_pkg::ADDR_SPEED_THR);
  assign wr_tmo = wr_i && (addr_i == hbs_pkg::ADDR_WAIT_TMO);
  assign wr_ctrl = wr_i && (addr_i == hbs_pkg::ADDR_CONTROL);

  // Out-of-range writes saturate, so the timers never see an illegal value.
  assign cmd_wval = (wval > hbs_pkg::MAX_CMD_DELAY) ? hbs_pkg::MAX_CMD_DELAY : wval;
  assign hold_wval = (wval > hbs_pkg::MAX_HOLD_TIME) ? hbs_pkg::MAX_HOLD_TIME :
                     (wval < hbs_pkg::MIN_HOLD_TIME) ? hbs_pkg::MIN_HOLD_TIME : wval;
  assign thr_wval = (wval > hbs_pkg::MAX_SPEED_THR) ? hbs_pkg::MAX_SPEED_THR : wval;
  assign tmo_wval = (wval > hbs_pkg::MAX_WAIT_TMO) ? hbs_pkg::MAX_WAIT_TMO :
                    (wval < hbs_pkg::MIN_WAIT_TMO) ? hbs_pkg::MIN_WAIT_TMO : wval;

  // Timing registers take writes in any state; the sequencer reads them live.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cmd_delay_q <= hbs_pkg::RST_CMD_DELAY;
      hold_time_q <= hbs_pkg::RST_HOLD_TIME;
      speed_thr_q <= hbs_pkg::RST_SPEED_THR;
      wait_tmo_q <= hbs_pkg::RST_WAIT_TMO;
    end else begin
      if (wr_cmd) cmd_delay_q <= cmd_wval;
      if (wr_hold) hold_time_q <= hold_wval;
      if (wr_thr) speed_thr_q <= thr_wval;
      if (wr_tmo) wait_tmo_q <= tmo_wval;
    end
  end

  // Function switch and output assignment.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      switch_q <= hbs_pkg::RST_SWITCH;
      assign_q <= hbs_pkg::RST_ASSIGN;
    end else if (wr_ctrl) begin
      switch_q <= wdata_i[hbs_pkg::CTRL_SWITCH_BIT];
      assign_q <= wdata_i[hbs_pkg::CTRL_ASSIGN_BIT];
    end
  end

  // Read mux; unmapped addresses read zero.
  logic [hbs_pkg::DATA_W-1:0] status_word;
  logic [hbs_pkg::DATA_W-1:0] rd_mux;

  assign status_word = (hbs_pkg::DATA_W'(state_q) << hbs_pkg::STAT_STATE_LSB)
                     | (hbs_pkg::DATA_W'(brake_q) << hbs_pkg::STAT_BRAKE_BIT)
                     | (hbs_pkg::DATA_W'(power_q) << hbs_pkg::STAT_POWER_BIT)
                     | (hbs_pkg::DATA_W'(stop_q) << hbs_pkg::STAT_STOP_BIT)
                     | (hbs_pkg::DATA_W'(ready_q) << hbs_pkg::STAT_READY_BIT)
                     | (hbs_pkg::DATA_W'(en_level_q) << hbs_pkg::STAT_ENABLE_BIT);
  assign rd_mux = (addr_i == hbs_pkg::ADDR_CMD_DELAY) ? hbs_pkg::DATA_W'(cmd_delay_q) :
                  (addr_i == hbs_pkg::ADDR_HOLD_TIME) ? hbs_pkg::DATA_W'(hold_time_q) :
                  (addr_i == hbs_pkg::ADDR_SPEED_THR) ? hbs_pkg::DATA_W'(speed_thr_q) :
                  (addr_i == hbs_pkg::ADDR_WAIT_TMO) ? hbs_pkg::DATA_W'(wait_tmo_q) :
                  (addr_i == hbs_pkg::ADDR_CONTROL) ? ((hbs_pkg::DATA_W'(switch_q) << hbs_pkg::CTRL_SWITCH_BIT)
                                                     | (hbs_pkg::DATA_W'(assign_q) << hbs_pkg::CTRL_ASSIGN_BIT)) :
                  (addr_i == hbs_pkg::ADDR_STATUS) ? status_word : '0;

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) rdata_q <= '0;
    else rdata_q <= rd_i ? rd_mux : '0;
  end

  // Enable pin: three flops, and a change counts once the last two agree.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_s3_q <= 1'b0;
      en_level_q <= 1'b0;
    end else begin
      en_s1_q <= servo_enable_i;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
      if (en_s2_q == en_s3_q) en_level_q <= en_s3_q;
    end
  end

  // Edge and condition decode for the sequencer.
  logic en_next;
  logic en_rise;
  logic en_fall;
  logic func_active;
  logic below_static;
  logic at_threshold;
  logic tmo_done;
  logic hold_done;
  logic move_hold_done;

  assign en_next = (en_s2_q == en_s3_q) ? en_s3_q : en_level_q;
  assign en_rise = en_next && !en_level_q;
  assign en_fall = !en_next && en_level_q;
  assign func_active = switch_q && assign_q;
  assign below_static = motor_speed_i < hbs_pkg::STATIC_LIMIT_RPM;
  assign at_threshold = motor_speed_i <= speed_thr_q;
  assign tmo_done = ms_cnt_q >= wait_tmo_q;
  assign hold_done = ms_cnt_q >= hold_time_q;
  assign move_hold_done = ms_cnt_q >= hbs_pkg::MOVE_HOLD_MS;

  // Next state. A rising enable wins over every stop step so a restart is never missed.
  always_comb begin
    state_d = state_q;
    if (!func_active) begin
      state_d = hbs_pkg::ST_DISABLED;
    end else if (en_rise) begin
      state_d = hbs_pkg::ST_ENABLED;
    end else begin
      case (state_q)
        hbs_pkg::ST_ENABLED: begin
          if (en_fall) begin
            state_d = below_static ? hbs_pkg::ST_STATIC_HOLD : hbs_pkg::ST_MOVE_WAIT;
          end
        end
        hbs_pkg::ST_STATIC_HOLD: begin
          if (hold_done) state_d = hbs_pkg::ST_DISABLED;
        end
        hbs_pkg::ST_MOVE_WAIT: begin
          if (at_threshold || tmo_done) state_d = hbs_pkg::ST_MOVE_HOLD;
        end
        hbs_pkg::ST_MOVE_HOLD: begin
          if (move_hold_done) state_d = hbs_pkg::ST_DISABLED;
        end
        default: begin
          state_d = hbs_pkg::ST_DISABLED;
        end
      endcase
    end
  end

  // The millisecond count restarts with every state change, together with the tick phase.
  logic state_change;

  assign state_change = (state_d != state_q);
  assign tick_if.restart = state_change;
  assign ms_cnt_d = state_change ? '0 :
                    (tick_if.tick && ms_cnt_q != '1) ? ms_cnt_q + PW'(1) : ms_cnt_q;

  // Output decode from the next state, and power from en_next while the function is inactive, so each output is one flop behind its cause.
  logic brake_d;
  logic power_d;
  logic stop_d;
  logic ready_d;

  // Release stays up through the moving wait so a spinning shaft is not clamped before the speed threshold or the wait timeout; ready is enabled-only.
  assign brake_d = (state_d == hbs_pkg::ST_ENABLED) || (state_d == hbs_pkg::ST_MOVE_WAIT);
  assign power_d = func_active ? (state_d != hbs_pkg::ST_DISABLED) : en_next;
  assign stop_d = (state_d == hbs_pkg::ST_MOVE_WAIT) || (state_d == hbs_pkg::ST_MOVE_HOLD);
  assign ready_d = (state_d == hbs_pkg::ST_ENABLED) && (ms_cnt_d >= cmd_delay_q);

  // Sequencer state and output registers.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_q <= hbs_pkg::ST_DISABLED;
      ms_cnt_q <= '0;
      brake_q <= 1'b0;
      power_q <= 1'b0;
      stop_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ms_cnt_q <= ms_cnt_d;
      brake_q <= brake_d;
      power_q <= power_d;
      stop_q <= stop_d;
      ready_q <= ready_d;
    end
  end

  // Outputs come straight from flops.
  assign rdata_o = rdata_q;
  assign brake_release_o = brake_q;
  assign power_stage_o = power_q;
  assign zero_speed_stop_o = stop_q;
  assign cmd_ready_o = ready_q;

  // Checks on the sequencer.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_enable_on;
    en_rise && func_active;
  endsequence

  sequence s_enable_off_slow;
    en_fall && func_active && state_q == hbs_pkg::ST_ENABLED && below_static;
  endsequence

  sequence s_enable_off_fast;
    en_fall && func_active && state_q == hbs_pkg::ST_ENABLED && !below_static;
  endsequence

  sequence s_move_release;
    state_q == hbs_pkg::ST_MOVE_WAIT && (at_threshold || tmo_done) && func_active && !en_rise;
  endsequence

  a_enable_on_both: assert property (s_enable_on |=> brake_q && power_q)
    else $error("Release and power did not rise together.");
  a_static_stop_entry: assert property (s_enable_off_slow |=> !brake_q && power_q && !stop_q)
    else $error("Static stop did not drop release while keeping power.");
  a_moving_stop_entry: assert property (s_enable_off_fast |=> brake_q && power_q && stop_q)
    else $error("Moving stop did not command zero-speed stop.");
  a_static_hold_end: assert property (state_q == hbs_pkg::ST_STATIC_HOLD && hold_done && !en_rise
                                      |=> !power_q ##1 !power_q)
    else $error("Power not removed after hold time.");
  a_speed_release: assert property (state_q == hbs_pkg::ST_MOVE_WAIT && at_threshold && !en_rise && func_active
                                    |=> !brake_q && power_q)
    else $error("Release not dropped at speed threshold.");
  a_timeout_release: assert property (state_q == hbs_pkg::ST_MOVE_WAIT && tmo_done && !en_rise && func_active
                                      |=> !brake_q)
    else $error("Release not dropped at wait timeout.");
  a_move_hold_len: assert property (state_q == hbs_pkg::ST_MOVE_HOLD |-> ms_cnt_q <= hbs_pkg::MOVE_HOLD_MS)
    else $error("Moving hold ran past its fixed time.");
  a_ready_after_delay: assert property (state_q == hbs_pkg::ST_ENABLED && ms_cnt_q >= cmd_delay_q
                                        && !en_fall && func_active |=> ready_q)
    else $error("Command ready late after the delay.");
  a_ready_needs_brake: assert property (ready_q |-> brake_q)
    else $error("Command ready without brake release.");
  a_abort_restart: assert property (s_enable_on and cmd_delay_q != '0 |=> !ready_q && ms_cnt_q == '0)
    else $error("Re-enable did not restart the acceptance delay.");
  a_param_write: assert property (wr_cmd && wval <= hbs_pkg::MAX_CMD_DELAY |=> cmd_delay_q == $past(wval))
    else $error("Delay write not applied at once.");
  a_inactive_hold: assert property (!func_active |=> !brake_q && !stop_q)
    else $error("Brake released while function inactive.");

  // Register clamps; the timers must never be handed a value outside its legal range.
  a_cmd_clamp: assert property (wr_cmd && wval > hbs_pkg::MAX_CMD_DELAY
                                |=> cmd_delay_q == hbs_pkg::MAX_CMD_DELAY)
    else $error("Delay write not saturated.");
  a_hold_clamp: assert property (wr_hold && wval < hbs_pkg::MIN_HOLD_TIME
                                 |=> hold_time_q == hbs_pkg::MIN_HOLD_TIME)
    else $error("Hold time write not raised to its minimum.");
  a_thr_clamp: assert property (wr_thr && wval > hbs_pkg::MAX_SPEED_THR
                                |=> speed_thr_q == hbs_pkg::MAX_SPEED_THR)
    else $error("Threshold write not saturated.");
  a_tmo_clamp: assert property (wr_tmo && wval > hbs_pkg::MAX_WAIT_TMO
                                |=> wait_tmo_q == hbs_pkg::MAX_WAIT_TMO)
    else $error("Timeout write not saturated.");

  // Output levels against the state; both are loaded from the same next-state value.
  a_static_hold_power: assert property (state_q == hbs_pkg::ST_STATIC_HOLD
                                        |-> power_q && !brake_q && !stop_q)
    else $error("Static hold without power or with release up.");
  a_move_wait_levels: assert property (state_q == hbs_pkg::ST_MOVE_WAIT
                                       |-> brake_q && power_q && stop_q)
    else $error("Moving wait dropped release, power or stop early.");
  a_stop_matches: assert property (stop_q == (state_q == hbs_pkg::ST_MOVE_WAIT
                                              || state_q == hbs_pkg::ST_MOVE_HOLD))
    else $error("Zero-speed stop does not match the moving sequence.");
  a_ready_only_enabled: assert property (ready_q |-> state_q == hbs_pkg::ST_ENABLED)
    else $error("Command ready outside the enabled state.");
  a_disabled_quiet: assert property (state_q == hbs_pkg::ST_DISABLED |-> !brake_q && !stop_q && !ready_q)
    else $error("Outputs active while disabled.");
  a_release_power_kept: assert property (s_move_release |=> power_q && stop_q && !brake_q)
    else $error("Power not kept after moving release.");
endmodule
`default_nettype wire

// [hbs_host_model.sv]
// Model of the host motion controller that faces the brake sequencer.
// Assumes the bench steers it through request inputs sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module hbs_host_model (
  // Clock.
  input wire logic clock_i,
  // Requests from the bench.
  input wire logic en_req_i,
  input wire logic [hbs_pkg::PARAM_W-1:0] speed_req_i,
  input wire logic cmd_req_i,
  // Drive side.
  input wire logic cmd_ready_i,
  output logic servo_enable_o,
  output logic [hbs_pkg::PARAM_W-1:0] motor_speed_o,
  output int cmd_count_o
);
  // Start with the servo off and the shaft at rest.
  initial begin
    servo_enable_o = 1'b0;
    motor_speed_o = 16'h0000;
    cmd_count_o = 0;
  end

  // Enable and speed follow the requests one edge late, like a real controller output stage.
  always @(posedge clock_i) begin
    servo_enable_o <= en_req_i;
    motor_speed_o <= speed_req_i;
    // A command is held back until the drive says it can take one, so none is lost.
    if (cmd_req_i && cmd_ready_i) begin
      cmd_count_o <= cmd_count_o + 1;
    end
  end
endmodule
`default_nettype wire

// [hbs_brake_seq_tb.sv]
// Self-checking bench of the holding-brake sequencer with a host controller model.
// Assumes a shortened tick of 10 cycles per millisecond so the sequences stay short.
`timescale 1ns/1ps
`default_nettype none
module hbs_brake_seq_tb;
  localparam int unsigned TK = 10;
  logic clock_i, rst_n_i, wr_i, rd_i, en_req, cmd_req;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o, rv;
  logic [15:0] speed_req, motor_speed;
  logic servo_enable, brake, power, stop, ready;
  logic [3:0] outs;
  int cmd_count, n_errors, checked, n;
  // Register table: address, value written, value expected back.
  logic [7:0] ta [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40, 8'h00, 8'h04, 8'h04, 8'h08, 8'h0c, 8'h0c};
  logic [31:0] tw [12] = '{0, 0, 0, 0, 0, 32'h5, 32'h258, 32'h0, 32'h7d0, 32'hfa0, 32'h0, 32'h7d0};
  logic [31:0] te [12] = '{32'hfa, 32'h96, 32'h1e, 32'h1f4, 32'h1, 0, 32'h1f4, 32'h1, 32'h3e8, 32'hbb8, 32'h1, 32'h3e8};

  assign outs = {ready, stop, power, brake};

  hbs_brake_seq #(.TICK_CYCLES(TK)) i_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .servo_enable_i(servo_enable), .motor_speed_i(motor_speed), .brake_release_o(brake),
    .power_stage_o(power), .zero_speed_stop_o(stop), .cmd_ready_o(ready)
  );
  hbs_host_model i_host (
    .clock_i(clock_i), .en_req_i(en_req), .speed_req_i(speed_req), .cmd_req_i(cmd_req),
    .cmd_ready_i(ready), .servo_enable_o(servo_enable), .motor_speed_o(motor_speed), .cmd_count_o(cmd_count)
  );

  // Free-running 100 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Compare and count; a mismatch is reported at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("Mismatches %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Writes leave one idle edge so a strobe is never raised and lowered in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask

  // Read data are sampled at the edge that ends the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(posedge clock_i);
    rv = rdata_o;
  endtask

  // Counts edges until an output reaches a level; running out of the bound ends the run.
  task automatic wait_out(input int b, input logic v, input int lim);
    n = 0;
    while (outs[b] !== v) begin
      @(posedge clock_i);
      n++;
      if (n > lim) begin
        n_errors++;
        $display("Error at %0t: output %0d stuck", $time, b);
        end_sim();
      end
    end
  endtask

  // Main sequence.
  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    en_req = 1'b0;
    cmd_req = 1'b0;
    speed_req = 16'h0000;
    n_errors = 0;
    checked = 0;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    // Reset values, an unmapped place, then clamped writes at both ends of the hold and timeout ranges and at the top of the delay and threshold ranges.
    for (int i = 0; i < 12; i++) begin
      if (i >= 5) wr(ta[i], tw[i]);
      rd(ta[i]);
      check(rv, te[i]);
    end
    wr(hbs_pkg::ADDR_CMD_DELAY, 32'h3);
    wr(hbs_pkg::ADDR_HOLD_TIME, 32'h2);
    wr(hbs_pkg::ADDR_SPEED_THR, 32'h1e);
    wr(hbs_pkg::ADDR_CONTROL, 32'h3);
    // Enable on: release and power together, commands held until the delay ends.
    cmd_req <= 1'b1;
    en_req <= 1'b1;
    wait_out(0, 1'b1, 20);
    check(power, 1'b1);
    check(ready, 1'b0);
    wait_out(3, 1'b1, 40);
    check(n >= 3 * TK && n <= 3 * TK + 3, 1'b1);
    check(cmd_count, 0);
    cmd_req <= 1'b0;
    rd(hbs_pkg::ADDR_STATUS);
    check(rv, 32'h1b1);
    check(cmd_count, 1);
    // Static stop just below the limit: brake at once, power for the hold time.
    speed_req <= 16'h001d;
    en_req <= 1'b0;
    wait_out(0, 1'b0, 20);
    check(power, 1'b1);
    check(stop, 1'b0);
    wait_out(1, 1'b0, 40);
    check(n >= 2 * TK && n <= 2 * TK + 3, 1'b1);
    // Enable again in mid hold: the stop is abandoned and the delay starts over.
    en_req <= 1'b1;
    wait_out(0, 1'b1, 20);
    en_req <= 1'b0;
    wait_out(0, 1'b0, 20);
    en_req <= 1'b1;
    wait_out(0, 1'b1, 20);
    check({power, ready}, 2'b10);
    wait_out(3, 1'b1, 40);
    check(n >= 3 * TK && n <= 3 * TK + 3, 1'b1);
    // Moving stop ended by the speed threshold, then the fixed 50 ms hold.
    speed_req <= 16'h0064;
    en_req <= 1'b0;
    wait_out(2, 1'b1, 20);
    repeat (30) @(posedge clock_i);
    check(brake, 1'b1);
    speed_req <= 16'h001e;
    wait_out(0, 1'b0, 6);
    check(power, 1'b1);
    wait_out(1, 1'b0, 520);
    check(n >= 50 * TK && n <= 50 * TK + 3, 1'b1);
    check(stop, 1'b0);
    // Exactly 30 rpm is a moving stop; a timeout written mid-wait takes effect at once.
    speed_req <= 16'h0000;
    en_req <= 1'b1;
    wait_out(3, 1'b1, 60);
    wr(hbs_pkg::ADDR_SPEED_THR, 32'h0);
    speed_req <= 16'h001e;
    en_req <= 1'b0;
    wait_out(2, 1'b1, 20);
    check(brake, 1'b1);
    wr(hbs_pkg::ADDR_WAIT_TMO, 32'h5);
    wait_out(0, 1'b0, 60);
    check(n >= 45 && n <= 52, 1'b1);
    wait_out(1, 1'b0, 520);
    // Output not assigned: no sequencing, power simply follows enable.
    wr(hbs_pkg::ADDR_CONTROL, 32'h1);
    en_req <= 1'b1;
    wait_out(1, 1'b1, 20);
    check(brake, 1'b0);
    en_req <= 1'b0;
    wait_out(1, 1'b0, 20);
    check(n <= 8, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
